// *** inc/ttpsw_pkg.sv ***
package ttpsw_pkg;

  // ------------------------------------------------------------
  // Page memory geometry
  // ------------------------------------------------------------
  localparam int        NUM_BLOCKS     = 10;
  localparam logic [3:0] EXT_BLOCK     = 4'h9;
  localparam logic [3:0] LAST_PAGE_EXT = 4'h8;
  localparam logic [3:0] LAST_PAGE_ALL = 4'h9;
  localparam logic [4:0] HDR_ROW       = 5'h00;
  localparam logic [4:0] STATUS_ROW    = 5'h19;
  localparam logic [5:0] CTRL_BYTES    = 6'h08;
  localparam logic [5:0] LAST_COL      = 6'h27;
  localparam logic [5:0] PAGE_CAPTURED_FLAG_COL     = 6'h08;
  localparam logic [5:0] FLAG_COL      = 6'h09;
  localparam logic [5:0] COL_LIMIT     = 6'h28;

  // ------------------------------------------------------------
  // Status byte fields
  // ------------------------------------------------------------
  localparam int ERR_BIT   = 4;
  localparam int PAGE_CAPTURED_FLAG_BIT = 4;
  localparam int FLAG_BIT  = 5;
  localparam int ISEQ_BIT  = 2;
  localparam int UPD_BIT   = 1;
  localparam int SER_BIT   = 0;
  localparam logic [5:0] ISEQ_COL = 6'h06;
  localparam logic [5:0] SER_COL  = 6'h07;

  // ------------------------------------------------------------
  // Write buffer
  // ------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic       last;
    logic       skip;
    logic [3:0] block;
    logic [4:0] row;
    logic [5:0] col;
    logic [7:0] data;
    logic [2:0] magazine_number;
    logic       flag;
  } ttpsw_wr_t;

  typedef enum logic [1:0] {W_IDLE, W_DATA, W_PAGE_CAPTURED_FLAG, W_FLAG} ttpsw_wstate_t;

endpackage : ttpsw_pkg

// *** core/ttpsw_fifo.sv ***
`timescale 1ns/1ns
module ttpsw_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             ready_reg;
  logic             ready_next;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  assign in_ready_out  = ready_reg;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];

  always_comb begin
    push        = in_valid_in & ready_reg;
    pop         = out_valid_out & out_ready_in;
    wr_ptr_next = push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
    count_next  = count_reg;
    if (push && !pop) begin
      count_next = CW'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = CW'(count_reg - 1'b1);
    end
    // Ready is registered, so it must reflect the count after this edge
    ready_next  = (count_next < CW'(DEPTH));
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      ready_reg  <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      ready_reg  <= ready_next;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

endmodule : ttpsw_fifo

// *** core/ttpsw_writer.sv ***
`timescale 1ns/1ns
module ttpsw_writer
  import ttpsw_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       extension_capture_disable_in,
  input  wire logic       acquisition_disable_in,
  input  wire logic       pkt_valid_in,
  input  wire logic [7:0] pkt_data_in,
  input  wire logic       pkt_first_in,
  input  wire logic [4:0] pkt_row_in,
  input  wire logic       pkt_ext_in,
  input  wire logic [4:0] pkt_ext_row_in,
  input  wire logic [3:0] pkt_request_in,
  input  wire logic [2:0] magazine_number_in,
  input  wire logic       magazine_error_in,
  input  wire logic       row25_status_flag_in,
  output logic            pkt_ready_out,
  output logic            mem_req_out,
  input  wire logic       mem_grant_in,
  output logic      [3:0] mem_block_out,
  output logic      [4:0] mem_row_out,
  output logic      [5:0] mem_col_out,
  output logic      [7:0] mem_data_out,
  output logic            serial_magazine_bit_out,
  output logic            interrupted_sequence_bit_out,
  output logic            update_bit_out
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // Returns {uncorrectable, nibble}; byte is P1 D1 P2 D2 P3 D3 P4 D4 from bit 0
  function automatic logic [4:0] ham84(input logic [7:0] b);
    logic fa;
    logic fb;
    logic fc;
    logic [3:0] d;
    fa = ~(b[0] ^ b[1] ^ b[5] ^ b[7]);
    fb = ~(b[1] ^ b[2] ^ b[3] ^ b[7]);
    fc = ~(b[1] ^ b[3] ^ b[4] ^ b[5]);
    d  = {b[7], b[5], b[3], b[1]};
    // Odd overall parity with a failed group means two bits are wrong
    if (!(^b)) begin
      d[0] = d[0] ^ (fa & fb & fc);
      d[1] = d[1] ^ (~fa & fb & fc);
      d[2] = d[2] ^ (fa & ~fb & fc);
      d[3] = d[3] ^ (fa & fb & ~fc);
      ham84 = {1'b0, d};
    end else begin
      ham84 = {(fa | fb | fc), d};
    end
  endfunction : ham84

  function automatic logic odd_ok(input logic [7:0] b);
    odd_ok = ^b;
  endfunction : odd_ok

  // ------------------------------------------------------------
  // Packet intake
  // ------------------------------------------------------------
  logic [5:0] colc_reg;
  logic [5:0] colc_next;
  logic       keep_reg;
  logic       keep_next;
  logic       ext_reg;
  logic       ext_next;
  logic [4:0] row_reg;
  logic [4:0] row_next;
  logic [3:0] req_reg;
  logic [3:0] req_next;
  logic [2:0] mag_reg;
  logic [2:0] mag_next;
  logic       flag_reg;
  logic       flag_next;
  logic       ser_reg;
  logic       ser_next;
  logic       iseq_reg;
  logic       iseq_next;
  logic       upd_reg;
  logic       upd_next;

  logic       acc;
  logic       ext_cur;
  logic [4:0] row_cur;
  logic [3:0] req_cur;
  logic [5:0] col_cur;
  logic       keep_cur;
  logic       hdr;
  logic [4:0] ham;
  logic       push_valid;
  ttpsw_wr_t  push_word;
  logic       fifo_ready;
  logic       fifo_valid;
  ttpsw_wr_t  fifo_word;
  logic       fifo_pop;

  assign pkt_ready_out                = fifo_ready;
  assign serial_magazine_bit_out      = ser_reg;
  assign interrupted_sequence_bit_out = iseq_reg;
  assign update_bit_out               = upd_reg;

  always_comb begin
    acc      = pkt_valid_in & fifo_ready;
    ext_cur  = pkt_first_in ? pkt_ext_in : ext_reg;
    row_cur  = pkt_first_in ? (pkt_ext_in ? pkt_ext_row_in : pkt_row_in) : row_reg;
    req_cur  = pkt_first_in ? pkt_request_in : req_reg;
    col_cur  = pkt_first_in ? 6'h00 : colc_reg;
    keep_cur = keep_reg;
    if (pkt_first_in) begin
      keep_cur = !magazine_error_in;
      keep_cur = keep_cur & (row_cur < STATUS_ROW);
      if (pkt_ext_in) begin
        keep_cur = keep_cur & !extension_capture_disable_in;
      end else if (extension_capture_disable_in) begin
        keep_cur = keep_cur & (pkt_request_in <= LAST_PAGE_ALL);
      end else begin
        keep_cur = keep_cur & (pkt_request_in <= LAST_PAGE_EXT);
      end
    end
    hdr = !ext_cur && (row_cur == HDR_ROW);
    ham = ham84(pkt_data_in);

    push_word       = '0;
    push_word.block = ext_cur ? EXT_BLOCK : req_cur;
    push_word.row   = row_cur;
    push_word.col   = col_cur;
    push_word.data  = pkt_data_in;
    push_word.magazine_number   = pkt_first_in ? magazine_number_in : mag_reg;
    push_word.flag  = pkt_first_in ? row25_status_flag_in : flag_reg;
    if (hdr && col_cur < CTRL_BYTES) begin
      // Errored control bytes still go in, flagged, so software can judge
      push_word.row  = STATUS_ROW;
      push_word.data = {3'h0, ham};
    end else if (hdr) begin
      push_word.skip = !odd_ok(pkt_data_in);
      push_word.data = {1'b0, pkt_data_in[6:0]};
      push_word.last = (col_cur == LAST_COL);
    end
    push_valid = acc && keep_cur && !acquisition_disable_in && (col_cur < COL_LIMIT)
                 && !(push_word.skip && !push_word.last);

    colc_next = acc ? ((col_cur < COL_LIMIT) ? 6'(col_cur + 6'h01) : col_cur) : colc_reg;
    keep_next = acc ? keep_cur : keep_reg;
    ext_next  = acc ? ext_cur : ext_reg;
    row_next  = acc ? row_cur : row_reg;
    req_next  = acc ? req_cur : req_reg;
    mag_next  = acc ? push_word.magazine_number : mag_reg;
    flag_next = acc ? push_word.flag : flag_reg;
    ser_next  = ser_reg;
    iseq_next = iseq_reg;
    upd_next  = upd_reg;
    if (push_valid && hdr && !ham[4]) begin
      if (col_cur == ISEQ_COL) begin
        iseq_next = ham[ISEQ_BIT];
        upd_next  = ham[UPD_BIT];
      end
      if (col_cur == SER_COL) begin
        ser_next = ham[SER_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      colc_reg <= 6'h00;
      keep_reg <= 1'b0;
      ext_reg  <= 1'b0;
      row_reg  <= 5'h00;
      req_reg  <= 4'h0;
      mag_reg  <= 3'h0;
      flag_reg <= 1'b0;
      ser_reg  <= 1'b0;
      iseq_reg <= 1'b0;
      upd_reg  <= 1'b0;
    end else begin
      colc_reg <= colc_next;
      keep_reg <= keep_next;
      ext_reg  <= ext_next;
      row_reg  <= row_next;
      req_reg  <= req_next;
      mag_reg  <= mag_next;
      flag_reg <= flag_next;
      ser_reg  <= ser_next;
      iseq_reg <= iseq_next;
      upd_reg  <= upd_next;
    end
  end

  ttpsw_fifo #(
    .WIDTH ($bits(ttpsw_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (push_valid),
    .in_data_in    (push_word),
    .in_ready_out  (fifo_ready),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_word),
    .out_ready_in  (fifo_pop)
  );

  // ------------------------------------------------------------
  // Memory write port
  // ------------------------------------------------------------
  ttpsw_wstate_t wstate_reg;
  ttpsw_wstate_t wstate_next;
  ttpsw_wr_t     hold_reg;
  ttpsw_wr_t     hold_next;
  logic          req_o_next;
  logic [3:0]    blk_o_next;
  logic [4:0]    row_o_next;
  logic [5:0]    col_o_next;
  logic [7:0]    dat_o_next;

  assign fifo_pop = (wstate_reg == W_IDLE);

  always_comb begin
    wstate_next = wstate_reg;
    hold_next   = hold_reg;
    unique case (wstate_reg)
      W_IDLE: begin
        if (fifo_valid) begin
          hold_next = fifo_word;
          if (!fifo_word.skip) begin
            wstate_next = W_DATA;
          end else if (fifo_word.last) begin
            wstate_next = W_PAGE_CAPTURED_FLAG;
          end
        end
      end
      W_DATA: begin
        if (mem_grant_in) begin
          wstate_next = hold_reg.last ? W_PAGE_CAPTURED_FLAG : W_IDLE;
        end
      end
      W_PAGE_CAPTURED_FLAG: begin
        if (mem_grant_in) begin
          wstate_next = W_FLAG;
        end
      end
      W_FLAG: begin
        if (mem_grant_in) begin
          wstate_next = W_IDLE;
        end
      end
    endcase
    if (acquisition_disable_in) begin
      wstate_next = W_IDLE;
    end

    // Address and data stay put while the request waits for its grant
    req_o_next = (wstate_next != W_IDLE);
    blk_o_next = mem_block_out;
    row_o_next = mem_row_out;
    col_o_next = mem_col_out;
    dat_o_next = mem_data_out;
    if (wstate_next != W_IDLE) begin
      blk_o_next = hold_next.block;
      row_o_next = hold_next.row;
      col_o_next = hold_next.col;
      dat_o_next = hold_next.data;
    end
    if (wstate_next == W_PAGE_CAPTURED_FLAG) begin
      row_o_next = STATUS_ROW;
      col_o_next = PAGE_CAPTURED_FLAG_COL;
      dat_o_next = 8'h00;
      dat_o_next[PAGE_CAPTURED_FLAG_BIT] = 1'b1;
      dat_o_next[2:0] = hold_next.magazine_number;
    end else if (wstate_next == W_FLAG) begin
      row_o_next = STATUS_ROW;
      col_o_next = FLAG_COL;
      dat_o_next = 8'h00;
      dat_o_next[FLAG_BIT] = hold_next.flag;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wstate_reg    <= W_IDLE;
      hold_reg      <= '0;
      mem_req_out   <= 1'b0;
      mem_block_out <= 4'h0;
      mem_row_out   <= 5'h00;
      mem_col_out   <= 6'h00;
      mem_data_out  <= 8'h00;
    end else begin
      wstate_reg    <= wstate_next;
      hold_reg      <= hold_next;
      mem_req_out   <= req_o_next;
      mem_block_out <= blk_o_next;
      mem_row_out   <= row_o_next;
      mem_col_out   <= col_o_next;
      mem_data_out  <= dat_o_next;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_block_in_range: assert property (mem_req_out |-> mem_block_out < 4'(NUM_BLOCKS))
    else $error("block index out of range");
  a_ext_block_nine: assert property (ext_cur |-> push_word.block == EXT_BLOCK)
    else $error("extension packet not aimed at block 9");
  a_ext_off_drop: assert property (
    pkt_first_in && pkt_ext_in && extension_capture_disable_in |-> !push_valid)
    else $error("extension packet captured while disabled");
  a_block_by_req: assert property (
    push_valid && pkt_first_in && !pkt_ext_in |-> push_word.block == pkt_request_in)
    else $error("page block differs from request number");
  a_hdr_err_flag: assert property (
    push_valid && hdr && col_cur < CTRL_BYTES |-> push_word.row == STATUS_ROW
    && push_word.data[7:5] == 3'h0 && push_word.data[ERR_BIT] == ham[4])
    else $error("status byte error flag wrong");
  a_status_cols: assert property (
    mem_req_out && mem_row_out == STATUS_ROW |-> mem_col_out <= FLAG_COL)
    else $error("software area of row 25 written");
  a_parity_msb: assert property (
    push_valid && hdr && col_cur >= CTRL_BYTES && !push_word.skip
    |-> push_word.data[7] == 1'b0 && odd_ok(pkt_data_in))
    else $error("header display byte parity handling wrong");
  a_mag_err_drop: assert property (pkt_first_in && magazine_error_in |-> !push_valid)
    else $error("packet kept despite magazine error");
  a_acq_off_quiet: assert property ($past(acquisition_disable_in) |-> !mem_req_out)
    else $error("memory write while acquisition disabled");
  a_page_captured_flag_follows: assert property (
    wstate_reg == W_DATA && hold_reg.last && mem_grant_in && !acquisition_disable_in
    |=> mem_req_out && mem_row_out == STATUS_ROW && mem_col_out == PAGE_CAPTURED_FLAG_COL
    && mem_data_out[PAGE_CAPTURED_FLAG_BIT])
    else $error("page_captured_flag byte not written after header");
  a_grant_hold: assert property (
    mem_req_out && !mem_grant_in && !acquisition_disable_in |=> mem_req_out
    && $stable(mem_data_out) && $stable(mem_col_out) && $stable(mem_row_out))
    else $error("pending write changed before grant");

endmodule : ttpsw_writer

// *** verif/ttpsw_mem_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Page memory with software-side arbiter
// ------------------------------------------------------------
module ttpsw_mem_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       slow_in,
  input  wire logic       mem_req_in,
  input  wire logic [3:0] mem_block_in,
  input  wire logic [4:0] mem_row_in,
  input  wire logic [5:0] mem_col_in,
  input  wire logic [7:0] mem_data_in,
  output logic            mem_grant_out
);
  logic [7:0] mem [0:9][0:25][0:39];
  int         wr_count;
  int         bad_count;
  logic [1:0] cnt_reg;

  // Known fill shows any byte that was never written
  initial begin
    wr_count = 0;
    bad_count = 0;
    foreach (mem[b, r, c]) mem[b][r][c] = 8'ha5;
  end

  // Slow: software owns the memory three cycles of four
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_reg <= 2'h0;
      mem_grant_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      mem_grant_out <= !slow_in || (cnt_reg == 2'h3);
      if (mem_req_in && mem_grant_out) begin
        wr_count <= wr_count + 1;
        if (mem_block_in > 4'h9 || mem_row_in > 5'h19 || mem_col_in > 6'h27) begin
          bad_count <= bad_count + 1;
        end else begin
          mem[mem_block_in][mem_row_in][mem_col_in] <= mem_data_in;
        end
      end
    end
  end
endmodule : ttpsw_mem_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  logic       clk_sys_in;
  logic       rst_in;
  logic       ext_dis;
  logic       acq_dis;
  logic       valid;
  logic [7:0] data;
  logic       first;
  logic [4:0] row;
  logic       ext;
  logic [4:0] ext_row;
  logic [3:0] req;
  logic [2:0] magazine_number;
  logic       mag_err;
  logic       flag;
  logic       slow;
  logic       ready;
  logic       mem_req_out;
  logic       grant;
  logic [3:0] blk;
  logic [4:0] mrow;
  logic [5:0] mcol;
  logic [7:0] mdata;
  logic       ser;
  logic       iseq;
  logic       upd;
  logic [7:0] pkt_b [0:39];
  logic [3:0] nib [0:7];
  int         err_count;
  int         comparisons;
  int         cycles;
  int         stalls;
  int         base;

  ttpsw_writer dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .extension_capture_disable_in(ext_dis),
    .acquisition_disable_in(acq_dis), .pkt_valid_in(valid), .pkt_data_in(data),
    .pkt_first_in(first), .pkt_row_in(row), .pkt_ext_in(ext), .pkt_ext_row_in(ext_row),
    .pkt_request_in(req), .magazine_number_in(magazine_number), .magazine_error_in(mag_err),
    .row25_status_flag_in(flag), .pkt_ready_out(ready), .mem_req_out(mem_req_out),
    .mem_grant_in(grant), .mem_block_out(blk), .mem_row_out(mrow), .mem_col_out(mcol),
    .mem_data_out(mdata), .serial_magazine_bit_out(ser),
    .interrupted_sequence_bit_out(iseq), .update_bit_out(upd)
  );

  ttpsw_mem_model mem_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .slow_in(slow), .mem_req_in(mem_req_out),
    .mem_block_in(blk), .mem_row_in(mrow), .mem_col_in(mcol), .mem_data_in(mdata),
    .mem_grant_out(grant)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] ham(input logic [3:0] d);
    logic p1, p2, p3, p4;
    p1 = ~(d[0] ^ d[2] ^ d[3]);
    p2 = ~(d[0] ^ d[1] ^ d[3]);
    p3 = ~(d[0] ^ d[1] ^ d[2]);
    p4 = ~(p1 ^ p2 ^ p3 ^ (^d));
    return {d[3], p4, d[2], p3, d[1], p2, d[0], p1};
  endfunction : ham

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic send_pkt();
    int i;
    int t;
    logic take;
    i = 0;
    t = 0;
    base = mem_u.wr_count;
    while (i < 40 && t < 4000) begin
      @(negedge clk_sys_in);
      valid = 1'b1;
      data = pkt_b[i];
      first = (i == 0);
      // Ready is registered, so its settled value here is what the edge sees
      take = (ready === 1'b1);
      @(posedge clk_sys_in);
      if (take) i++;
      else stalls++;
      t++;
    end
    @(negedge clk_sys_in);
    valid = 1'b0;
    first = 1'b0;
    check(8'(i), 8'h28);
  endtask : send_pkt

  // Writes come at least every fourth cycle, so a long quiet spell means done
  task automatic drain();
    int q;
    int t;
    q = 0;
    t = 0;
    while (q < 12 && t < 3000) begin
      @(negedge clk_sys_in);
      q = (mem_req_out === 1'b0) ? q + 1 : 0;
      t++;
    end
    check(8'(q), 8'h0c);
  endtask : drain

  task automatic fill_hdr();
    nib = '{4'h7, 4'h2, 4'h9, 4'h3, 4'h8, 4'h1, 4'h6, 4'h1};
    for (int i = 0; i < 8; i++) pkt_b[i] = ham(nib[i]);
    for (int i = 8; i < 40; i++) pkt_b[i] = {(^7'(i + 16)) ^ (i % 2 == 0), 7'(i + 16)};
  endtask : fill_hdr

  task automatic fill_raw(input logic [7:0] b);
    for (int i = 0; i < 40; i++) pkt_b[i] = b + 8'(i);
  endtask : fill_raw

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_header();
    fill_hdr();
    pkt_b[2] = pkt_b[2] ^ 8'h03;
    // Single flipped data bit must be corrected without a flag
    pkt_b[4] = pkt_b[4] ^ 8'h02;
    row = 5'h00;
    req = 4'h3;
    magazine_number = 3'h5;
    flag = 1'b1;
    send_pkt();
    drain();
    for (int i = 0; i < 8; i++) begin
      if (i != 2) check(mem_u.mem[3][25][i], {4'h0, nib[i]});
    end
    check(mem_u.mem[3][25][2] & 8'hf0, 8'h10);
    for (int i = 8; i < 40; i++) begin
      check(mem_u.mem[3][0][i], (i % 2 == 0) ? 8'(i + 16) : 8'ha5);
    end
    check(mem_u.mem[3][25][8], 8'h15);
    check(mem_u.mem[3][25][9], 8'h20);
    for (int i = 10; i < 24; i++) check(mem_u.mem[3][25][i], 8'ha5);
    check(8'(mem_u.wr_count - base), 8'h1a);
    check({5'h00, ser, iseq, upd}, 8'h07);
    $display("test header done");
  endtask : t_header

  task automatic t_ext();
    fill_raw(8'h40);
    row = 5'h18;
    ext = 1'b1;
    ext_row = 5'h05;
    req = 4'h2;
    send_pkt();
    drain();
    check(mem_u.mem[9][5][0], 8'h40);
    check(mem_u.mem[9][5][39], 8'h67);
    check(mem_u.mem[2][24][0], 8'ha5);
    ext_dis = 1'b1;
    ext_row = 5'h07;
    send_pkt();
    drain();
    check(8'(mem_u.wr_count - base), 8'h00);
    ext = 1'b0;
    row = 5'h01;
    req = 4'h9;
    send_pkt();
    drain();
    check(mem_u.mem[9][1][13], 8'h4d);
    fill_hdr();
    row = 5'h00;
    magazine_number = 3'h2;
    flag = 1'b0;
    send_pkt();
    drain();
    check(mem_u.mem[9][25][8], 8'h12);
    check(mem_u.mem[9][25][9], 8'h00);
    ext_dis = 1'b0;
    row = 5'h02;
    send_pkt();
    drain();
    check(8'(mem_u.wr_count - base), 8'h00);
    $display("test extension done");
  endtask : t_ext

  task automatic t_refuse();
    fill_raw(8'h30);
    req = 4'h4;
    for (int k = 0; k < 3; k++) begin
      mag_err = (k == 0);
      acq_dis = (k == 1);
      row = (k == 2) ? 5'h19 : 5'h01;
      send_pkt();
      drain();
      check(8'(mem_u.wr_count - base), 8'h00);
      check(mem_u.mem[4][row][12], 8'ha5);
    end
    mag_err = 1'b0;
    acq_dis = 1'b0;
    $display("test refusal done");
  endtask : t_refuse

  task automatic t_slow();
    fill_raw(8'h10);
    slow = 1'b1;
    row = 5'h03;
    req = 4'h0;
    stalls = 0;
    send_pkt();
    drain();
    check(8'(stalls > 0), 8'h01);
    for (int i = 0; i < 40; i++) check(mem_u.mem[0][3][i], 8'(8'h10 + i));
    check(8'(mem_u.bad_count), 8'h00);
    slow = 1'b0;
    $display("test slow memory done");
  endtask : t_slow

  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    {rst_in, ext_dis, acq_dis, valid, first, ext, mag_err, flag, slow} = 9'h100;
    {data, row, ext_row, req, magazine_number} = '0;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (20) @(negedge clk_sys_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    t_header();
    t_ext();
    t_refuse();
    t_slow();
    finish_test();
  end

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      finish_test();
    end
  end
endmodule : tb_top
